// ==== include/ifb_pkg.sv ====
// Constants, tables and types shared by the interrupt flag and enable bank.
package ifb_pkg;

  localparam int ADDR_W   = 3;
  localparam int DATA_W   = 8;
  localparam int NUM_REG  = 6;
  localparam int SRC_W    = 12;
  localparam int GRP_W    = 3;
  localparam int NUM_VEC  = 15;
  localparam int VEC_W    = 4;
  localparam int NUM_PIN  = 2;
  localparam int EDGE_W   = 2;
  localparam int EN_SHIFT = 4;

  localparam logic [ADDR_W-1:0] ADDR_EDGE   = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_A = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_B = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_C = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_D = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_GROUP  = 3'h5;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h6;
  localparam logic [ADDR_W-1:0] ADDR_MASK   = 3'h7;

  localparam logic [DATA_W-1:0] RESET_VALUE = 8'h00;
  localparam logic [DATA_W-1:0] IMPL_MASK [NUM_REG] = '{8'h0F, 8'h7F, 8'hFF, 8'hFF, 8'hFF, 8'h77};
  localparam logic [DATA_W-1:0] STATUS_MASK = 8'h0F;

  localparam int PIN0_EDGE_LSB = 0;
  localparam int PIN1_EDGE_LSB = 2;
  localparam int GIE_BIT       = 0;
  localparam int PIN1_FLAG_BIT = 6;
  localparam int PIN0_FLAG_BIT = 5;
  localparam int CMP0_FLAG_BIT = 4;
  localparam int GROUP_FLAG_BIT = 7;

  localparam int ST_PIN0    = 0;
  localparam int ST_PIN1    = 1;
  localparam int ST_SERVICE = 2;
  localparam int ST_BLOCKED = 3;

  typedef enum logic [EDGE_W-1:0] {
    EDGE_OFF  = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } ifb_edge_e;

  // Event input order: cmp0, cmp1, tick0, tick1, serial if, low volt, eeprom, converter, t0a, t0p, t2a, t2p.
  localparam int SRC_REG [SRC_W] = '{1, 4, 4, 4, 2, 2, 2, 2, 3, 3, 3, 3};
  localparam int SRC_BIT [SRC_W] = '{4, 6, 4, 5, 4, 5, 7, 6, 7, 6, 5, 4};
  // Group event order: timer-1 period, timer-1 match A, serial port.
  localparam int GRP_BIT [GRP_W] = '{4, 5, 6};

  // Vector order is also the priority order, vector 0 first.
  localparam int VEC_REG [NUM_VEC] = '{1, 1, 1, 4, 4, 4, 2, 2, 2, 2, 3, 3, 3, 3, 4};
  localparam int VEC_BIT [NUM_VEC] = '{5, 6, 4, 6, 4, 5, 4, 5, 7, 6, 7, 6, 5, 4, 7};
  localparam int VEC_EN  [NUM_VEC] = '{2, 3, 1, 2, 0, 1, 0, 1, 3, 2, 3, 2, 1, 0, 3};
  localparam logic [VEC_W-1:0] VEC_NONE = 4'hF;

endpackage

// ==== include/ifb_edge_if.sv ====
// Interface carrying the external pins, their edge fields and the detected hits.
`timescale 1ns/10ps
interface ifb_edge_if;
  logic [ifb_pkg::NUM_PIN-1:0]                 pin;
  logic [ifb_pkg::NUM_PIN*ifb_pkg::EDGE_W-1:0] edge_sel;
  logic [ifb_pkg::NUM_PIN-1:0]                 hit;
  modport bank (output pin, output edge_sel, input hit);
  modport det  (input pin, input edge_sel, output hit);
endinterface

// ==== core/ifb_edge_detect.sv ====
// Edge detector for the external interrupt pins.
`timescale 1ns/10ps
module ifb_edge_detect (
  input wire logic clk,
  input wire logic rstn,
  ifb_edge_if.det  e
);

  logic [ifb_pkg::NUM_PIN-1:0] prev;
  logic                        armed;

  // The first cycle after reset only loads the history, so a pin that is already
  // high at reset is not taken for a rising edge.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prev  <= '0;
      armed <= 1'b0;
    end else begin
      prev  <= e.pin;
      armed <= 1'b1;
    end
  end

  genvar i;
  generate
    for (i = 0; i < ifb_pkg::NUM_PIN; i++) begin : g_pin
      wire [ifb_pkg::EDGE_W-1:0] sel  = e.edge_sel[i*ifb_pkg::EDGE_W +: ifb_pkg::EDGE_W];
      wire                       rise = armed & e.pin[i] & ~prev[i];
      wire                       fall = armed & ~e.pin[i] & prev[i];
      assign e.hit[i] = (rise & (sel == ifb_pkg::EDGE_RISE | sel == ifb_pkg::EDGE_BOTH))
                      | (fall & (sel == ifb_pkg::EDGE_FALL | sel == ifb_pkg::EDGE_BOTH));
    end
  endgenerate

endmodule

// ==== core/ifb_irq_bank.sv ====
// Interrupt request flag and enable bank with edge select, priority and core hand-off.
//
// Added by the designer: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
module ifb_irq_bank (
  input  wire logic                          CORE_CLK,
  input  wire logic                          RSTN,
  input  wire logic [ifb_pkg::ADDR_W-1:0]    REG_ADDR,
  input  wire logic [ifb_pkg::DATA_W-1:0]    REG_WDATA,
  input  wire logic                          REG_WR,
  input  wire logic                          REG_RD,
  output logic      [ifb_pkg::DATA_W-1:0]    REG_RDATA,
  input  wire logic                          EXT_IRQ_PIN_0,
  input  wire logic                          EXT_IRQ_PIN_1,
  input  wire logic [ifb_pkg::SRC_W-1:0]     SRC_EVENT,
  input  wire logic [ifb_pkg::GRP_W-1:0]     GROUP_EVENT,
  input  wire logic                          IRQ_ACK,
  output logic                               IRQ_REQ,
  output logic      [ifb_pkg::VEC_W-1:0]     IRQ_VEC,
  output logic                               GLOBAL_IRQ_ENABLE,
  output logic                               IRQ_OUT
);

  // ****************************************************************
  // Register storage
  // ****************************************************************

  logic [ifb_pkg::DATA_W-1:0] regs     [ifb_pkg::NUM_REG];
  logic [ifb_pkg::DATA_W-1:0] set_m    [ifb_pkg::NUM_REG];
  logic [ifb_pkg::DATA_W-1:0] clr_m    [ifb_pkg::NUM_REG];
  logic [ifb_pkg::DATA_W-1:0] next_reg [ifb_pkg::NUM_REG];
  logic [ifb_pkg::DATA_W-1:0] status;
  logic [ifb_pkg::DATA_W-1:0] mask;
  logic [ifb_pkg::DATA_W-1:0] next_status;
  logic [ifb_pkg::DATA_W-1:0] next_rdata;

  // Writes replace the stored value, hardware clears come next and hardware sets
  // last, so an event in the cycle of a clearing write or a service is kept.
  function automatic logic [ifb_pkg::DATA_W-1:0] ifb_next_value(
    input logic [ifb_pkg::DATA_W-1:0] cur,
    input logic                       wr,
    input logic [ifb_pkg::DATA_W-1:0] wd,
    input logic [ifb_pkg::DATA_W-1:0] impl,
    input logic [ifb_pkg::DATA_W-1:0] clr,
    input logic [ifb_pkg::DATA_W-1:0] set
  );
    logic [ifb_pkg::DATA_W-1:0] base;
    base = wr ? wd : cur;
    return ((base & ~clr) | set) & impl;
  endfunction

  // Lowest pending index wins; the caller checks that something is pending.
  function automatic logic [ifb_pkg::VEC_W-1:0] ifb_first(
    input logic [ifb_pkg::NUM_VEC-1:0] req
  );
    logic [ifb_pkg::VEC_W-1:0] idx;
    idx = ifb_pkg::VEC_NONE;
    for (int v = ifb_pkg::NUM_VEC - 1; v >= 0; v--) begin
      if (req[v]) begin
        idx = v[ifb_pkg::VEC_W-1:0];
      end
    end
    return idx;
  endfunction

  // ****************************************************************
  // Address decode
  // ****************************************************************

  wire wr_edge   = REG_WR & (REG_ADDR == ifb_pkg::ADDR_EDGE);
  wire wr_ctrl_a = REG_WR & (REG_ADDR == ifb_pkg::ADDR_CTRL_A);
  wire wr_ctrl_b = REG_WR & (REG_ADDR == ifb_pkg::ADDR_CTRL_B);
  wire wr_ctrl_c = REG_WR & (REG_ADDR == ifb_pkg::ADDR_CTRL_C);
  wire wr_ctrl_d = REG_WR & (REG_ADDR == ifb_pkg::ADDR_CTRL_D);
  wire wr_group  = REG_WR & (REG_ADDR == ifb_pkg::ADDR_GROUP);
  wire wr_status = REG_WR & (REG_ADDR == ifb_pkg::ADDR_STATUS);
  wire wr_mask   = REG_WR & (REG_ADDR == ifb_pkg::ADDR_MASK);

  wire [ifb_pkg::NUM_REG-1:0] wr_sel = {wr_group, wr_ctrl_d, wr_ctrl_c, wr_ctrl_b, wr_ctrl_a, wr_edge};

  // ****************************************************************
  // Named fields
  // ****************************************************************

  wire [ifb_pkg::DATA_W-1:0] ext_edge_select    = regs[ifb_pkg::ADDR_EDGE];
  wire [ifb_pkg::DATA_W-1:0] primary_irq_ctrl_a = regs[ifb_pkg::ADDR_CTRL_A];
  wire [ifb_pkg::DATA_W-1:0] primary_irq_ctrl_b = regs[ifb_pkg::ADDR_CTRL_B];
  wire [ifb_pkg::DATA_W-1:0] primary_irq_ctrl_c = regs[ifb_pkg::ADDR_CTRL_C];
  wire [ifb_pkg::DATA_W-1:0] primary_irq_ctrl_d = regs[ifb_pkg::ADDR_CTRL_D];
  wire [ifb_pkg::DATA_W-1:0] group_irq_ctrl     = regs[ifb_pkg::ADDR_GROUP];

  wire [ifb_pkg::EDGE_W-1:0] pin0_edge_field = ext_edge_select[ifb_pkg::PIN0_EDGE_LSB +: ifb_pkg::EDGE_W];
  wire [ifb_pkg::EDGE_W-1:0] pin1_edge_field = ext_edge_select[ifb_pkg::PIN1_EDGE_LSB +: ifb_pkg::EDGE_W];

  wire global_irq_enable = primary_irq_ctrl_a[ifb_pkg::GIE_BIT];

  wire serial_port_req_flag   = group_irq_ctrl[ifb_pkg::GRP_BIT[2]];
  wire timer1_match_a_flag    = group_irq_ctrl[ifb_pkg::GRP_BIT[1]];
  wire timer1_period_flag     = group_irq_ctrl[ifb_pkg::GRP_BIT[0]];
  wire serial_port_req_enable = group_irq_ctrl[ifb_pkg::GRP_BIT[2] - ifb_pkg::EN_SHIFT];
  wire timer1_match_a_enable  = group_irq_ctrl[ifb_pkg::GRP_BIT[1] - ifb_pkg::EN_SHIFT];
  wire timer1_period_enable   = group_irq_ctrl[ifb_pkg::GRP_BIT[0] - ifb_pkg::EN_SHIFT];

  wire group_pending = (serial_port_req_flag & serial_port_req_enable)
                     | (timer1_match_a_flag & timer1_match_a_enable)
                     | (timer1_period_flag & timer1_period_enable);

  // ****************************************************************
  // External pin edge detection
  // ****************************************************************

  ifb_edge_if edge_bus ();

  assign edge_bus.pin      = {EXT_IRQ_PIN_1, EXT_IRQ_PIN_0};
  assign edge_bus.edge_sel = {pin1_edge_field, pin0_edge_field};

  ifb_edge_detect u_edge (
    .clk  (CORE_CLK),
    .rstn (RSTN),
    .e    (edge_bus.det)
  );

  wire pin0_hit = edge_bus.hit[0];
  wire pin1_hit = edge_bus.hit[1];

  // ****************************************************************
  // Request vectors and priority
  // ****************************************************************

  logic [ifb_pkg::NUM_VEC-1:0] vec_flag;
  logic [ifb_pkg::NUM_VEC-1:0] vec_en;

  genvar gv;
  generate
    for (gv = 0; gv < ifb_pkg::NUM_VEC; gv++) begin : g_vec
      assign vec_flag[gv] = regs[ifb_pkg::VEC_REG[gv]][ifb_pkg::VEC_BIT[gv]];
      assign vec_en[gv]   = regs[ifb_pkg::VEC_REG[gv]][ifb_pkg::VEC_EN[gv]];
    end
  endgenerate

  wire [ifb_pkg::NUM_VEC-1:0] pending = vec_flag & vec_en;
  wire                        any_pending = |pending;
  wire [ifb_pkg::VEC_W-1:0]   top_vec = ifb_first(pending);

  // An acknowledge counts only while a request is offered.
  wire service = IRQ_ACK & IRQ_REQ;

  // ****************************************************************
  // Hardware set and clear masks
  // ****************************************************************

  always_comb begin
    for (int r = 0; r < ifb_pkg::NUM_REG; r++) begin
      set_m[r] = '0;
      clr_m[r] = '0;
    end
    for (int s = 0; s < ifb_pkg::SRC_W; s++) begin
      if (SRC_EVENT[s]) begin
        set_m[ifb_pkg::SRC_REG[s]][ifb_pkg::SRC_BIT[s]] = 1'b1;
      end
    end
    for (int g = 0; g < ifb_pkg::GRP_W; g++) begin
      if (GROUP_EVENT[g]) begin
        set_m[ifb_pkg::ADDR_GROUP][ifb_pkg::GRP_BIT[g]] = 1'b1;
      end
    end
    set_m[ifb_pkg::ADDR_CTRL_A][ifb_pkg::PIN0_FLAG_BIT] = pin0_hit;
    set_m[ifb_pkg::ADDR_CTRL_A][ifb_pkg::PIN1_FLAG_BIT] = pin1_hit;
    set_m[ifb_pkg::ADDR_CTRL_D][ifb_pkg::GROUP_FLAG_BIT] = group_pending;
    if (service) begin
      clr_m[ifb_pkg::VEC_REG[IRQ_VEC]][ifb_pkg::VEC_BIT[IRQ_VEC]] = 1'b1;
      clr_m[ifb_pkg::ADDR_CTRL_A][ifb_pkg::GIE_BIT] = 1'b1;
    end
  end

  // ****************************************************************
  // Register update
  // ****************************************************************

  genvar gr;
  generate
    for (gr = 0; gr < ifb_pkg::NUM_REG; gr++) begin : g_reg
      assign next_reg[gr] = ifb_next_value(regs[gr], wr_sel[gr], REG_WDATA, ifb_pkg::IMPL_MASK[gr],
                                           clr_m[gr], set_m[gr]);

      always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
          regs[gr] <= ifb_pkg::RESET_VALUE;
        end else begin
          regs[gr] <= next_reg[gr];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Status and mask for the summary interrupt line
  // ****************************************************************

  wire [ifb_pkg::DATA_W-1:0] status_set = {
    4'h0,
    any_pending & ~global_irq_enable,
    service,
    pin1_hit,
    pin0_hit
  };

  // Writing a one clears a status bit unless the same event arrives again.
  assign next_status = (((wr_status ? status & ~REG_WDATA : status)) | status_set) & ifb_pkg::STATUS_MASK;

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      status <= ifb_pkg::RESET_VALUE;
      mask   <= ifb_pkg::RESET_VALUE;
    end else begin
      status <= next_status;
      if (wr_mask) begin
        mask <= REG_WDATA & ifb_pkg::STATUS_MASK;
      end
    end
  end

  // ****************************************************************
  // Read port
  // ****************************************************************

  always_comb begin
    next_rdata = ifb_pkg::RESET_VALUE;
    if (REG_RD) begin
      unique case (REG_ADDR)
        ifb_pkg::ADDR_EDGE:   next_rdata = ext_edge_select;
        ifb_pkg::ADDR_CTRL_A: next_rdata = primary_irq_ctrl_a;
        ifb_pkg::ADDR_CTRL_B: next_rdata = primary_irq_ctrl_b;
        ifb_pkg::ADDR_CTRL_C: next_rdata = primary_irq_ctrl_c;
        ifb_pkg::ADDR_CTRL_D: next_rdata = primary_irq_ctrl_d;
        ifb_pkg::ADDR_GROUP:  next_rdata = group_irq_ctrl;
        ifb_pkg::ADDR_STATUS: next_rdata = status;
        ifb_pkg::ADDR_MASK:   next_rdata = mask;
      endcase
    end
  end

  // ****************************************************************
  // Outputs to the core
  // ****************************************************************

  // The request is withdrawn in the cycle after a service because the global
  // enable is already being cleared; the core re-enables it to allow nesting.
  wire next_req = global_irq_enable & any_pending & ~service;

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      REG_RDATA         <= ifb_pkg::RESET_VALUE;
      IRQ_REQ           <= 1'b0;
      IRQ_VEC           <= ifb_pkg::VEC_NONE;
      GLOBAL_IRQ_ENABLE <= 1'b0;
      IRQ_OUT           <= 1'b0;
    end else begin
      REG_RDATA         <= next_rdata;
      IRQ_REQ           <= next_req;
      IRQ_VEC           <= next_req ? top_vec : ifb_pkg::VEC_NONE;
      GLOBAL_IRQ_ENABLE <= next_reg[ifb_pkg::ADDR_CTRL_A][ifb_pkg::GIE_BIT];
      IRQ_OUT           <= |(next_status & mask);
    end
  end

endmodule

// ==== verif/ifb_irq_bank_asserts.sv ====
// Port-level assertions for the interrupt flag and enable bank.
`timescale 1ns/10ps
module ifb_irq_bank_asserts (
  input wire logic                       CORE_CLK,
  input wire logic                       RSTN,
  input wire logic [ifb_pkg::ADDR_W-1:0] REG_ADDR,
  input wire logic [ifb_pkg::DATA_W-1:0] REG_WDATA,
  input wire logic                       REG_WR,
  input wire logic                       REG_RD,
  input wire logic [ifb_pkg::DATA_W-1:0] REG_RDATA,
  input wire logic                       IRQ_ACK,
  input wire logic                       IRQ_REQ,
  input wire logic [ifb_pkg::VEC_W-1:0]  IRQ_VEC,
  input wire logic                       GLOBAL_IRQ_ENABLE,
  input wire logic                       IRQ_OUT
);
  logic                       rd_q;
  logic [ifb_pkg::ADDR_W-1:0] addr_q;

  always_ff @(posedge CORE_CLK) begin
    rd_q   <= RSTN && REG_RD;
    addr_q <= REG_ADDR;
  end

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RSTN);

  property p_gie_write;
    REG_WR && REG_ADDR == ifb_pkg::ADDR_CTRL_A && REG_WDATA[0] && !IRQ_REQ |-> ##[1:2] GLOBAL_IRQ_ENABLE;
  endproperty
  a_gie_write: assert property (p_gie_write) else $error("global enable not set by write");
  property p_req_gie;
    IRQ_REQ |-> GLOBAL_IRQ_ENABLE || $past(GLOBAL_IRQ_ENABLE);
  endproperty
  a_req_gie: assert property (p_req_gie) else $error("request without global enable");
  property p_rose_req;
    $rose(IRQ_REQ) |-> $past(GLOBAL_IRQ_ENABLE);
  endproperty
  a_rose_req: assert property (p_rose_req) else $error("request rose while disabled");
  property p_ack;
    IRQ_ACK && IRQ_REQ |=> !IRQ_REQ && !GLOBAL_IRQ_ENABLE;
  endproperty
  a_ack: assert property (p_ack) else $error("service did not block nesting");
  property p_gie_source;
    $rose(GLOBAL_IRQ_ENABLE) |-> $past(REG_WR) || $past(REG_WR, 2);
  endproperty
  a_gie_source: assert property (p_gie_source) else $error("global enable set without write");
  // A pending request may only be displaced by a higher one while software leaves the bank alone.
  property p_vec_hold;
    IRQ_REQ && !IRQ_ACK && !REG_WR && !$past(REG_WR) |=> IRQ_REQ && IRQ_VEC <= $past(IRQ_VEC);
  endproperty
  a_vec_hold: assert property (p_vec_hold) else $error("request lost or lower vector offered");
  property p_vec_valid;
    IRQ_REQ |-> IRQ_VEC < ifb_pkg::NUM_VEC;
  endproperty
  a_vec_valid: assert property (p_vec_valid) else $error("request with no valid vector");
  property p_unimpl;
    rd_q && addr_q < ifb_pkg::NUM_REG |-> (REG_RDATA & ~ifb_pkg::IMPL_MASK[addr_q]) == 8'h00;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented bit read as one");

  c_ack: cover property (IRQ_ACK && IRQ_REQ);
  c_group: cover property (IRQ_REQ && IRQ_VEC == 4'hE);
  c_irq_out: cover property ($rose(IRQ_OUT));
endmodule

bind ifb_irq_bank ifb_irq_bank_asserts u_chk (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .IRQ_ACK(IRQ_ACK),
  .IRQ_REQ(IRQ_REQ), .IRQ_VEC(IRQ_VEC), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .IRQ_OUT(IRQ_OUT));

// ==== verif/ifb_core_model.sv ====
// Behavioural model of the processor core that takes interrupts from the bank.
`timescale 1ns/10ps
module ifb_core_model (
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire logic                      en,
  input  wire logic [3:0]                lat,
  input  wire logic                      req,
  input  wire logic [ifb_pkg::VEC_W-1:0] vec,
  output logic                           ack,
  output logic      [ifb_pkg::VEC_W-1:0] last_vec
);
  logic [3:0] wait_cnt;

  // The acknowledge is one pulse raised only while a request stands; lat plays a slow core.
  always_ff @(posedge clk) begin
    if (!rstn || !req || ack) begin
      wait_cnt <= 4'h0;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
    ack <= rstn && en && req && !ack && wait_cnt >= lat;
    if (!rstn) begin
      last_vec <= ifb_pkg::VEC_NONE;
    end else if (ack && req) begin
      last_vec <= vec;
    end
  end
endmodule

// ==== verif/tb_irq_flag_enable_bank.sv ====
// Self-checking testbench for the interrupt flag and enable bank.
`timescale 1ns/10ps
module tb_irq_flag_enable_bank;
  logic                       clk = 1'b0;
  logic                       rstn = 1'b0;
  logic [ifb_pkg::ADDR_W-1:0] addr = 3'h0;
  logic [ifb_pkg::DATA_W-1:0] wdata = 8'h00;
  logic [ifb_pkg::DATA_W-1:0] rdata;
  logic                       wr = 1'b0;
  logic                       rd = 1'b0;
  logic                       p0 = 1'b0;
  logic                       p1 = 1'b0;
  logic [ifb_pkg::SRC_W-1:0]  src = 12'h000;
  logic [ifb_pkg::GRP_W-1:0]  grp = 3'h0;
  logic                       core_en = 1'b0;
  logic [3:0]                 lat = 4'h0;
  logic                       ack, req, gie, irq;
  logic [ifb_pkg::VEC_W-1:0]  vec, last_vec;
  logic [7:0]                 d;
  int                         mismatches = 0;
  int                         num_checks = 0;
  int                         cyc = 0;

  ifb_irq_bank dut (.CORE_CLK(clk), .RSTN(rstn), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .EXT_IRQ_PIN_0(p0), .EXT_IRQ_PIN_1(p1), .SRC_EVENT(src),
    .GROUP_EVENT(grp), .IRQ_ACK(ack), .IRQ_REQ(req), .IRQ_VEC(vec), .GLOBAL_IRQ_ENABLE(gie), .IRQ_OUT(irq));
  ifb_core_model core (.clk(clk), .rstn(rstn), .en(core_en), .lat(lat), .req(req), .vec(vec), .ack(ack),
    .last_vec(last_vec));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // The longest path is a few hundred cycles; a hang runs into this ceiling.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      test_done();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wrr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge clk);
    wr    <= 1'b0;
  endtask
  task automatic rdr(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  task automatic ev(input logic [11:0] s, input logic [2:0] g);
    @(posedge clk);
    src <= s;
    grp <= g;
    @(posedge clk);
    src <= 12'h000;
    grp <= 3'h0;
  endtask
  task automatic setp(input logic a, input logic b);
    @(posedge clk);
    p0 <= a;
    p1 <= b;
    repeat (4) @(posedge clk);
  endtask
  task automatic wait_gie(input logic v);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (gie !== v && n < 40);
    chk({7'h00, gie}, {7'h00, v});
  endtask
  task automatic serve(input logic [7:0] ctrl_a, input logic [7:0] exp_vec);
    wrr(3'h1, ctrl_a);
    wait_gie(1'b1);
    wait_gie(1'b0);
    chk({4'h0, last_vec}, exp_vec);
  endtask

  task automatic t_reset_values();
    for (int a = 0; a < 8; a++) begin
      rdr(3'(a), d);
      chk(d, 8'h00);
    end
  endtask
  task automatic t_access();
    for (int a = 0; a < 6; a++) wrr(3'(a), 8'hFF);
    for (int a = 0; a < 6; a++) begin
      rdr(3'(a), d);
      chk(d, ifb_pkg::IMPL_MASK[a]);
    end
    @(negedge clk);
    chk(rdata, 8'h00);
    for (int a = 5; a >= 0; a--) wrr(3'(a), 8'h00);
    rdr(3'h4, d);
    chk(d, 8'h00);
  endtask
  task automatic t_pins();
    wrr(3'h6, 8'hFF);
    // Pin 1 always runs the complementary mode, so a swapped field shows up.
    for (int m = 0; m < 4; m++) begin
      wrr(3'h0, {4'h0, 2'(3 - m), 2'(m)});
      wrr(3'h1, 8'h00);
      setp(1'b1, 1'b1);
      rdr(3'h1, d);
      chk(d, m[0] ? 8'h20 : 8'h40);
      wrr(3'h1, 8'h00);
      setp(1'b0, 1'b0);
      rdr(3'h1, d);
      chk(d, m[1] ? 8'h20 : 8'h40);
    end
    rdr(3'h6, d);
    chk(d, 8'h03);
    chk({7'h00, irq}, 8'h00);
    wrr(3'h7, 8'h01);
    repeat (2) @(negedge clk);
    chk({7'h00, irq}, 8'h01);
    wrr(3'h6, 8'h01);
    repeat (2) @(negedge clk);
    chk({7'h00, irq}, 8'h00);
    rdr(3'h6, d);
    chk(d, 8'h02);
    wrr(3'h7, 8'h00);
    core_en <= 1'b1;
    wrr(3'h0, 8'h05);
    wrr(3'h1, 8'h0D);
    setp(1'b1, 1'b1);
    wait_gie(1'b0);
    chk({4'h0, last_vec}, 8'h00);
    rdr(3'h1, d);
    chk(d, 8'h4C);
    serve(8'h4D, 8'h01);
    rdr(3'h1, d);
    chk(d, 8'h0C);
    setp(1'b0, 1'b0);
    wrr(3'h1, 8'h00);
    wrr(3'h0, 8'h00);
  endtask
  task automatic t_priority();
    wrr(3'h1, 8'h01);
    ev(12'h020, 3'h0);
    repeat (3) @(negedge clk);
    chk({7'h00, req}, 8'h00);
    rdr(3'h2, d);
    chk(d, 8'h20);
    wrr(3'h1, 8'h02);
    wrr(3'h2, 8'h0F);
    wrr(3'h3, 8'h0F);
    wrr(3'h4, 8'h07);
    ev(12'hFFF, 3'h0);
    rdr(3'h4, d);
    chk(d, 8'h77);
    // Every single-source vector from the comparator down is taken once, in priority order.
    for (int k = 0; k < 12; k++) begin
      lat <= k[0] ? 4'h5 : 4'h0;
      serve((k == 0) ? 8'h13 : 8'h03, 8'(2 + k));
    end
    rdr(3'h1, d);
    chk(d, 8'h02);
    rdr(3'h4, d);
    chk(d, 8'h07);
    rdr(3'h2, d);
    chk(d, 8'h0F);
    ev(12'h040, 3'h0);
    rdr(3'h2, d);
    chk(d, 8'h8F);
    chk({7'h00, req}, 8'h00);
    wrr(3'h2, 8'h00);
    wrr(3'h3, 8'h00);
    wrr(3'h4, 8'h00);
    wrr(3'h1, 8'h00);
  endtask
  task automatic t_group();
    wrr(3'h5, 8'h04);
    ev(12'h000, 3'h7);
    rdr(3'h5, d);
    chk(d, 8'h74);
    rdr(3'h4, d);
    chk(d, 8'h80);
    wrr(3'h4, 8'h88);
    serve(8'h01, 8'h0E);
    rdr(3'h5, d);
    chk(d, 8'h74);
    wrr(3'h5, 8'h00);
    wrr(3'h4, 8'h00);
    rdr(3'h4, d);
    chk(d, 8'h00);
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset_values();
    t_access();
    t_pins();
    t_priority();
    t_group();
    test_done();
  end
endmodule
